// [include/amc_pkg.sv]
// constants shared by the main counter block and its testbench
// assumes a 32-bit axi4-lite master; every register is one aligned word, byte address = index * 4
package amc_pkg;

  // ****************************************************************
  // address map, register indexes
  // ****************************************************************
  localparam int unsigned ADDR_W          = 18;
  localparam int unsigned IDX_W           = 16;
  localparam logic [15:0] IDX_MODE        = 16'h00D1;
  localparam logic [15:0] IDX_COUNT_LOW   = 16'h00D9;
  localparam logic [15:0] IDX_FLAGS       = 16'h00E1;
  localparam logic [15:0] IDX_COUNT_HIGH  = 16'h00E9;
  localparam logic [15:0] IDX_SNAP_LOW    = 16'h00F2;
  localparam logic [15:0] IDX_SNAP_HIGH   = 16'h00F3;
  localparam logic [15:0] IDX_PRESCALE    = 16'hA0A5;
  localparam logic [15:0] IDX_RELOAD_LOW  = 16'hA0A6;
  localparam logic [15:0] IDX_RELOAD_HIGH = 16'hA0A7;
  localparam logic [15:0] IDX_IRQ_STATUS  = 16'hA0B0;
  localparam logic [15:0] IDX_IRQ_MASK    = 16'hA0B1;

  // ****************************************************************
  // counter_mode_control fields
  // ****************************************************************
  localparam int unsigned MODE_IDLE_STOP   = 7;
  localparam int unsigned MODE_RELOAD_EN   = 6;
  localparam int unsigned MODE_BYTE_WIDTH  = 5;
  localparam int unsigned MODE_BYTE_OVF    = 4;
  localparam int unsigned MODE_CNT_EN      = 3;
  localparam int unsigned MODE_OVF_IRQ_EN  = 2;
  localparam int unsigned MODE_CMP_IRQ_EN  = 1;
  localparam int unsigned MODE_CMP_SNAP_EN = 0;

  // ****************************************************************
  // counter_flags and interrupt status fields
  // ****************************************************************
  localparam int unsigned FLAG_OVF      = 7;
  localparam int unsigned FLAG_CMP      = 6;
  localparam int unsigned CHANNEL_COUNT = 6;
  localparam int unsigned IRQ_OVF       = 0;
  localparam int unsigned IRQ_CMP       = 1;

  // ****************************************************************
  // reset values and bus answers
  // ****************************************************************
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [1:0]  RST_IRQ     = 2'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// [logic/amc_prescaler.sv]
// clock prescaler: one tick every (divide + 1) system clocks while run is high
// assumes divide and run come from logic on the same clock
`timescale 1ns/1ps

module amc_prescaler #(
  parameter int unsigned DIV_W = 8
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divide,
  // count enable out
  output logic                  tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } amc_presc_state_s;

  amc_presc_state_s state_q;
  amc_presc_state_s state_d;

  // a zero divide gives a tick on every clock
  assign tick = run && (state_q.cnt >= divide);

  always_comb begin
    state_d = state_q;
    if (!run || tick) begin
      state_d.cnt = '0;
    end else begin
      state_d.cnt = DIV_W'(state_q.cnt + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// [logic/amc_top.sv]
// main time-base counter of the counter array, with an axi4-lite register slave
// assumes channel flag set pulses and the comparator event come from logic on aclk
//
// Function
// - The counter advances at the system clock divided by the prescale field plus one.
// - The reload-enable bit selects free-run or reload from the reload registers at each overflow.
// - An overflow raises an interrupt request only while the overflow interrupt enable is set.
// - A count equal to the compare value raises an interrupt only while the compare interrupt enable is set.
// - Compare value writes land in a holding stage, not directly in the value that is compared.
// - A software or hardware snapshot trigger copies high and low count bytes into the snapshot registers.
// - Every read of the low count byte also snapshots the full count.
// - With the comparator trigger enabled a comparator event snapshots the count, otherwise it is ignored.
// - The high count byte is a read-only register and writes to it are ignored.
// - Bits 5 to 0 of the flag register hold the six channel flags, bits 7 and 6 overflow and compare.
// - Separate 8-bit reload values exist for the high and low count bytes.
// - Snapshot addresses read the snapshot bytes and writes there load the compare value bytes.
`timescale 1ns/1ps

module amc_top #(
  parameter int unsigned ADDR_W = amc_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  // axi4-lite write data
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // axi4-lite write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // axi4-lite read address
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  // axi4-lite read data
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // surrounding chip events
  input  wire logic [5:0]        channel_flag_set,
  input  wire logic              comparator_event,
  input  wire logic              cpu_idle,
  // time base to the channels and interrupt
  output logic [15:0]            count_value,
  output logic                   irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic        aw_held;
    logic [15:0] aw_idx;
    logic        aw_ok;
    logic        w_held;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic [7:0]  mode;
    logic [7:0]  prescale;
    logic [7:0]  flags;
    logic [15:0] count;
    logic [7:0]  reload_low;
    logic [7:0]  reload_high;
    logic [15:0] snap;
    logic [15:0] cmp_hold;
    logic [15:0] cmp_active;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
  } amc_top_state_s;

  amc_top_state_s state_q;
  amc_top_state_s state_d;
  logic           tick;
  logic           run;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic [15:0] amc_index(input logic [ADDR_W-1:0] addr);
    amc_index = 16'(addr[ADDR_W-1:2]);
  endfunction

  function automatic logic amc_mapped(input logic [ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = amc_index(addr);
    amc_mapped = 1'b0;
    if (addr[1:0] == 2'h0) begin
      case (idx)
        amc_pkg::IDX_MODE,
        amc_pkg::IDX_COUNT_LOW,
        amc_pkg::IDX_FLAGS,
        amc_pkg::IDX_COUNT_HIGH,
        amc_pkg::IDX_SNAP_LOW,
        amc_pkg::IDX_SNAP_HIGH,
        amc_pkg::IDX_PRESCALE,
        amc_pkg::IDX_RELOAD_LOW,
        amc_pkg::IDX_RELOAD_HIGH,
        amc_pkg::IDX_IRQ_STATUS,
        amc_pkg::IDX_IRQ_MASK: begin
          amc_mapped = 1'b1;
        end
        default: begin
          amc_mapped = 1'b0;
        end
      endcase
    end
  endfunction

  // ****************************************************************
  // prescaler
  // ****************************************************************
  // idle stop only bites when software asked for it
  assign run = state_q.mode[amc_pkg::MODE_CNT_EN] &&
               !(state_q.mode[amc_pkg::MODE_IDLE_STOP] && cpu_idle);

  amc_prescaler #(
    .DIV_W (8)
  ) u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (run),
    .divide  (state_q.prescale),
    .tick    (tick)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign awready     = !state_q.aw_held && !state_q.bvalid;
  assign wready      = !state_q.w_held && !state_q.bvalid;
  assign bvalid      = state_q.bvalid;
  assign bresp       = state_q.bresp;
  assign arready     = !state_q.rvalid;
  assign rvalid      = state_q.rvalid;
  assign rdata       = {24'h000000, state_q.rdata};
  assign rresp       = state_q.rresp;
  assign count_value = state_q.count;
  assign irq         = |(state_q.irq_status & state_q.irq_mask);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic        do_write;
    logic        rd_take;
    logic [15:0] rd_idx;
    logic [7:0]  flag_clr;
    logic [1:0]  irq_clr;
    logic        snap_now;
    logic        ovf_evt;
    logic        cmp_evt;
    logic        low_wrap;
    logic        full_wrap;
    logic [15:0] next_count;

    do_write   = 1'b0;
    rd_take    = 1'b0;
    rd_idx     = 16'h0000;
    flag_clr   = 8'h00;
    irq_clr    = 2'h0;
    snap_now   = 1'b0;
    ovf_evt    = 1'b0;
    cmp_evt    = 1'b0;
    low_wrap   = 1'b0;
    full_wrap  = 1'b0;
    next_count = state_q.count;
    state_d    = state_q;

    // write channels taken in either order, applied once both are held
    if (awvalid && awready) begin
      state_d.aw_held = 1'b1;
      state_d.aw_idx  = amc_index(awaddr);
      state_d.aw_ok   = amc_mapped(awaddr);
    end
    if (wvalid && wready) begin
      state_d.w_held  = 1'b1;
      state_d.w_byte  = wdata[7:0];
      state_d.w_lane0 = wstrb[0];
    end
    if (state_q.bvalid && bready) begin
      state_d.bvalid = 1'b0;
    end
    do_write = state_q.aw_held && state_q.w_held && !state_q.bvalid;
    if (do_write) begin
      state_d.aw_held = 1'b0;
      state_d.w_held  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = state_q.aw_ok ? amc_pkg::RESP_OKAY : amc_pkg::RESP_SLVERR;
      if (state_q.aw_ok && state_q.w_lane0) begin
        case (state_q.aw_idx)
          amc_pkg::IDX_MODE: begin
            state_d.mode = state_q.w_byte;
          end
          amc_pkg::IDX_PRESCALE: begin
            state_d.prescale = state_q.w_byte;
          end
          amc_pkg::IDX_FLAGS: begin
            flag_clr = ~state_q.w_byte;
          end
          amc_pkg::IDX_RELOAD_LOW: begin
            state_d.reload_low = state_q.w_byte;
          end
          amc_pkg::IDX_RELOAD_HIGH: begin
            state_d.reload_high = state_q.w_byte;
          end
          amc_pkg::IDX_SNAP_LOW: begin
            state_d.cmp_hold[7:0] = state_q.w_byte;
          end
          amc_pkg::IDX_SNAP_HIGH: begin
            state_d.cmp_hold[15:8] = state_q.w_byte;
          end
          amc_pkg::IDX_IRQ_MASK: begin
            state_d.irq_mask = state_q.w_byte[1:0];
          end
          // count bytes and irq status take no write
          default: begin
            state_d.mode = state_d.mode;
          end
        endcase
      end
    end

    // read: data registered, side effects in the cycle of the take
    if (state_q.rvalid && rready) begin
      state_d.rvalid = 1'b0;
    end
    rd_take = arvalid && arready;
    if (rd_take) begin
      rd_idx         = amc_index(araddr);
      state_d.rvalid = 1'b1;
      state_d.rdata  = 8'h00;
      state_d.rresp  = amc_mapped(araddr) ? amc_pkg::RESP_OKAY : amc_pkg::RESP_SLVERR;
      if (amc_mapped(araddr)) begin
        case (rd_idx)
          amc_pkg::IDX_MODE: begin
            state_d.rdata = state_q.mode;
          end
          amc_pkg::IDX_COUNT_LOW: begin
            state_d.rdata = state_q.count[7:0];
            snap_now      = 1'b1;
          end
          amc_pkg::IDX_FLAGS: begin
            state_d.rdata = state_q.flags;
          end
          amc_pkg::IDX_COUNT_HIGH: begin
            state_d.rdata = state_q.count[15:8];
          end
          amc_pkg::IDX_SNAP_LOW: begin
            state_d.rdata = state_q.snap[7:0];
          end
          amc_pkg::IDX_SNAP_HIGH: begin
            state_d.rdata = state_q.snap[15:8];
          end
          amc_pkg::IDX_PRESCALE: begin
            state_d.rdata = state_q.prescale;
          end
          amc_pkg::IDX_RELOAD_LOW: begin
            state_d.rdata = state_q.reload_low;
          end
          amc_pkg::IDX_RELOAD_HIGH: begin
            state_d.rdata = state_q.reload_high;
          end
          amc_pkg::IDX_IRQ_STATUS: begin
            state_d.rdata = {6'h00, state_q.irq_status};
            irq_clr       = 2'h3;
          end
          amc_pkg::IDX_IRQ_MASK: begin
            state_d.rdata = {6'h00, state_q.irq_mask};
          end
          default: begin
            state_d.rdata = 8'h00;
          end
        endcase
      end
    end

    // counter
    if (!state_q.mode[amc_pkg::MODE_CNT_EN]) begin
      // a stopped counter shows zero and takes any new compare value at once
      state_d.count      = amc_pkg::RST_WORD;
      state_d.cmp_active = state_q.cmp_hold;
    end else if (tick) begin
      low_wrap  = (state_q.count[7:0] == 8'hFF);
      full_wrap = (state_q.count == 16'hFFFF);
      if (state_q.mode[amc_pkg::MODE_BYTE_WIDTH]) begin
        // high byte frozen, low byte wraps on its own
        ovf_evt    = low_wrap;
        next_count = {state_q.count[15:8], 8'(state_q.count[7:0] + 8'h01)};
        if (ovf_evt && state_q.mode[amc_pkg::MODE_RELOAD_EN]) begin
          next_count[7:0] = state_q.reload_low;
        end
      end else begin
        ovf_evt    = state_q.mode[amc_pkg::MODE_BYTE_OVF] ? low_wrap : full_wrap;
        next_count = 16'(state_q.count + 16'h0001);
        if (ovf_evt && state_q.mode[amc_pkg::MODE_RELOAD_EN]) begin
          // a byte overflow reloads the low byte only, so the high byte still carries
          if (state_q.mode[amc_pkg::MODE_BYTE_OVF]) begin
            next_count[7:0] = state_q.reload_low;
          end else begin
            next_count = {state_q.reload_high, state_q.reload_low};
          end
        end
      end
      state_d.count = next_count;
      cmp_evt       = (next_count == state_q.cmp_active);
      // while counting, the compare value swaps only at overflow, so a half-written pair never matches
      if (ovf_evt) begin
        state_d.cmp_active = state_q.cmp_hold;
      end
    end

    // snapshot: current count, before this cycle's increment
    if (comparator_event && state_q.mode[amc_pkg::MODE_CMP_SNAP_EN]) begin
      snap_now = 1'b1;
    end
    if (snap_now) begin
      state_d.snap = state_q.count;
    end

    // sticky bits: an event in the clearing cycle survives
    state_d.flags = (state_q.flags & ~flag_clr) |
                    {ovf_evt, cmp_evt, channel_flag_set};
    state_d.irq_status = state_q.irq_status & ~irq_clr;
    if (ovf_evt && state_q.mode[amc_pkg::MODE_OVF_IRQ_EN]) begin
      state_d.irq_status[amc_pkg::IRQ_OVF] = 1'b1;
    end
    if (cmp_evt && state_q.mode[amc_pkg::MODE_CMP_IRQ_EN]) begin
      state_d.irq_status[amc_pkg::IRQ_CMP] = 1'b1;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q             <= '0;
      state_q.mode        <= amc_pkg::RST_BYTE;
      state_q.prescale    <= amc_pkg::RST_BYTE;
      state_q.flags       <= amc_pkg::RST_BYTE;
      state_q.count       <= amc_pkg::RST_WORD;
      state_q.reload_low  <= amc_pkg::RST_BYTE;
      state_q.reload_high <= amc_pkg::RST_BYTE;
      state_q.snap        <= amc_pkg::RST_WORD;
      state_q.cmp_hold    <= amc_pkg::RST_WORD;
      state_q.cmp_active  <= amc_pkg::RST_WORD;
      state_q.irq_status  <= amc_pkg::RST_IRQ;
      state_q.irq_mask    <= amc_pkg::RST_IRQ;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// [testbench/amc_props.sv]
// concurrent checks on the ports of the main counter block
// assumes every port sits on aclk with the synchronous active-low reset
`timescale 1ns/1ps

module amc_props (
  // ****
  // clock, reset, bus handshakes
  // ****
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // time base and interrupt
  input wire logic [15:0] count_value,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data not returned one cycle after take");
  a_read_hold: assert property ($fell(rvalid) |-> $past(rready))
    else $error("read data dropped without rready");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read address accepted while data pending");
  a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response missing");
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  a_write_hold: assert property ($fell(bvalid) |-> $past(bready))
    else $error("write response dropped without bready");
  // reloads and disables only ever follow a low byte wrap or land on zero
  a_count_step: assert property ($changed(count_value) |->
    count_value == $past(count_value) + 16'h1 || count_value[7:0] == $past(count_value[7:0]) + 8'h1
    || count_value == 16'h0 || $past(count_value[7:0]) == 8'hFF)
    else $error("count moved by an illegal step");

  c_slverr: cover property (bvalid && bready && bresp == 2'h2);
  c_irq: cover property ($rose(irq));
  c_read: cover property (rvalid && rready);
endmodule

bind amc_top amc_props u_props (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .count_value(count_value), .irq(irq));

// [testbench/tb.sv]
// self-checking bench for amc_top: registers, counting, flags, snapshots, interrupt
// assumes amc_pkg and the checker are compiled ahead of it
`timescale 1ns/1ps

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module tb;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;
  logic [31:0] wdata = 32'h0;
  logic [5:0]  channel_flag_set = 6'h0;
  logic        comparator_event = 1'h0, cpu_idle = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] count_value;
  int          error_cnt = 0, tests_run = 0;

  always #25 aclk = ~aclk;

  amc_top uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .channel_flag_set(channel_flag_set), .comparator_event(comparator_event), .cpu_idle(cpu_idle),
    .count_value(count_value), .irq(irq));

  // ****
  // bus tasks
  // ****
  // handshakes are judged at the negedge, where nothing moves before the next rising edge
  task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er = amc_pkg::RESP_OKAY);
    logic ta, tw, bv;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      bv = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!bv);
    bready <= 1'h0;
    `CHK("bresp", er, r)
  endtask

  task automatic rd(input logic [15:0] i, output logic [7:0] d, input logic [1:0] er = amc_pkg::RESP_OKAY);
    logic ta, rv;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      rv = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end while (!rv);
    rready <= 1'h0;
    `CHK("rresp", er, r)
  endtask

  task automatic rc(input logic [15:0] i, input logic [7:0] e);
    logic [7:0] d;
    rd(i, d);
    `CHK($sformatf("reg %h", i), e, d)
  endtask

  task automatic wait_cnt(input logic [15:0] v);
    int n;
    n = 0;
    // first look at a negedge, never in the slot of the edge that moves the count
    do begin
      @(negedge aclk);
      n++;
    end while (count_value !== v && n < 5000);
    `CHK("count", v, count_value)
  endtask

  task automatic pulse_cmp();
    @(posedge aclk);
    comparator_event <= 1'h1;
    @(posedge aclk);
    comparator_event <= 1'h0;
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_reset();
    logic [15:0] ix [10] = '{amc_pkg::IDX_MODE, amc_pkg::IDX_COUNT_LOW, amc_pkg::IDX_FLAGS,
      amc_pkg::IDX_COUNT_HIGH, amc_pkg::IDX_SNAP_LOW, amc_pkg::IDX_SNAP_HIGH, amc_pkg::IDX_PRESCALE,
      amc_pkg::IDX_RELOAD_LOW, amc_pkg::IDX_RELOAD_HIGH, amc_pkg::IDX_IRQ_MASK};
    foreach (ix[k]) rc(ix[k], amc_pkg::RST_BYTE);
    `CHK("irq", 1'h0, irq)
  endtask

  task automatic t_access();
    logic [7:0] d;
    wr(16'h0000, 8'h11, amc_pkg::RESP_SLVERR);
    rd(16'h0000, d, amc_pkg::RESP_SLVERR);
    wr(amc_pkg::IDX_COUNT_HIGH, 8'h55);
    rc(amc_pkg::IDX_COUNT_HIGH, 8'h00);
    wr(amc_pkg::IDX_RELOAD_HIGH, 8'hA5);
    rc(amc_pkg::IDX_RELOAD_HIGH, 8'hA5);
  endtask

  task automatic t_prescale(input logic [7:0] p);
    int n;
    logic [15:0] c;
    wr(amc_pkg::IDX_PRESCALE, p);
    wr(amc_pkg::IDX_MODE, 8'h08);
    wait_cnt(16'h0002);
    c = count_value;
    n = 0;
    while (count_value === c && n < 600) begin
      @(negedge aclk);
      n++;
    end
    `CHK("tick gap", p + 1, n)
    wr(amc_pkg::IDX_MODE, 8'h00);
    repeat (5) @(negedge aclk);
    `CHK("count off", 16'h0000, count_value)
  endtask

  task automatic t_byte_ovf();
    wr(amc_pkg::IDX_PRESCALE, 8'h00);
    wr(amc_pkg::IDX_MODE, 8'h18);
    wait_cnt(16'h0102);
    rc(amc_pkg::IDX_FLAGS, 8'h80);
    rc(amc_pkg::IDX_IRQ_STATUS, 8'h00);
    pulse_cmp();
    channel_flag_set <= 6'h2A;
    @(posedge aclk);
    channel_flag_set <= 6'h00;
    rc(amc_pkg::IDX_FLAGS, 8'hAA);
    wr(amc_pkg::IDX_FLAGS, 8'hFF);
    rc(amc_pkg::IDX_FLAGS, 8'hAA);
    wr(amc_pkg::IDX_FLAGS, 8'h00);
    rc(amc_pkg::IDX_FLAGS, 8'h00);
    wr(amc_pkg::IDX_MODE, 8'h00);
  endtask

  task automatic t_reload();
    wr(amc_pkg::IDX_RELOAD_LOW, 8'hF0);
    wr(amc_pkg::IDX_IRQ_MASK, 8'h01);
    wr(amc_pkg::IDX_MODE, 8'h6C);
    wait_cnt(16'h00FF);
    @(negedge aclk);
    `CHK("reloaded", 16'h00F0, count_value)
    @(negedge aclk);
    `CHK("irq", 1'h1, irq)
    wr(amc_pkg::IDX_MODE, 8'h00);
    wr(amc_pkg::IDX_IRQ_MASK, 8'h00);
    @(negedge aclk);
    `CHK("irq masked", 1'h0, irq)
    wr(amc_pkg::IDX_IRQ_MASK, 8'h01);
    @(negedge aclk);
    `CHK("irq unmasked", 1'h1, irq)
    rc(amc_pkg::IDX_IRQ_STATUS, 8'h01);
    @(negedge aclk);
    `CHK("irq cleared", 1'h0, irq)
    rc(amc_pkg::IDX_IRQ_STATUS, 8'h00);
    rc(amc_pkg::IDX_FLAGS, 8'h80);
    wr(amc_pkg::IDX_FLAGS, 8'h00);
    // 16-bit byte overflow: low byte reloads, high byte carries, held compare swaps in
    wr(amc_pkg::IDX_MODE, 8'h58);
    wr(amc_pkg::IDX_SNAP_HIGH, 8'h01);
    wr(amc_pkg::IDX_SNAP_LOW, 8'hF4);
    wait_cnt(16'h00FF);
    @(negedge aclk);
    `CHK("byte reload", 16'h01F0, count_value)
    wait_cnt(16'h01F5);
    wr(amc_pkg::IDX_MODE, 8'h00);
    rc(amc_pkg::IDX_FLAGS, 8'hC0);
    wr(amc_pkg::IDX_FLAGS, 8'h00);
  endtask

  task automatic t_compare();
    wr(amc_pkg::IDX_SNAP_LOW, 8'h20);
    wr(amc_pkg::IDX_SNAP_HIGH, 8'h00);
    wr(amc_pkg::IDX_IRQ_MASK, 8'h02);
    wr(amc_pkg::IDX_MODE, 8'h0A);
    wait_cnt(16'h0030);
    rc(amc_pkg::IDX_FLAGS, 8'h40);
    rc(amc_pkg::IDX_IRQ_STATUS, 8'h02);
    // a new value written mid-run waits for the next overflow
    wr(amc_pkg::IDX_SNAP_LOW, 8'h60);
    wr(amc_pkg::IDX_FLAGS, 8'h00);
    wait_cnt(16'h0070);
    rc(amc_pkg::IDX_FLAGS, 8'h00);
    `CHK("irq", 1'h0, irq)
    wr(amc_pkg::IDX_MODE, 8'h00);
  endtask

  task automatic t_snap();
    wr(amc_pkg::IDX_PRESCALE, 8'hFF);
    wr(amc_pkg::IDX_MODE, 8'h08);
    wait_cnt(16'h0002);
    rc(amc_pkg::IDX_COUNT_LOW, 8'h02);
    rc(amc_pkg::IDX_SNAP_LOW, 8'h02);
    rc(amc_pkg::IDX_SNAP_HIGH, 8'h00);
    wait_cnt(16'h0003);
    pulse_cmp();
    rc(amc_pkg::IDX_SNAP_LOW, 8'h02);
    wr(amc_pkg::IDX_MODE, 8'h09);
    wait_cnt(16'h0004);
    pulse_cmp();
    rc(amc_pkg::IDX_SNAP_LOW, 8'h04);
    // idle stop with the cpu idle freezes the count even at full speed
    cpu_idle <= 1'h1;
    wr(amc_pkg::IDX_MODE, 8'h88);
    wr(amc_pkg::IDX_PRESCALE, 8'h00);
    repeat (4) @(negedge aclk);
    `CHK("idle hold", 16'h0004, count_value)
    wr(amc_pkg::IDX_MODE, 8'h00);
    cpu_idle <= 1'h0;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_access();
    t_prescale(8'h00);
    t_prescale(8'h02);
    t_byte_ovf();
    t_reload();
    t_compare();
    t_snap();
    report_and_stop();
  end

  // whole run needs well under ten thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    $display("Error watchdog expired");
    report_and_stop();
  end
endmodule
